// file: src/drive_monitor.sv
/*
  Drive monitor and fault record block: user-select monitor, power-on item,
  terminal snapshots, active trip record and five-entry history.
  Assumes terminal pins are asynchronous, measurements and trip inputs
  come from SYS_CLK logic, and software uses the plain register port.
*/
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Select 0-4 picks monitored quantity
// - Label follows power, torque, V1, I2
// - I2 shows mA or V by switch
// - Power-on item latched once from select reset value 0
// - One bit per input terminal
// - Two output bits, reset to zero
// - Record: type, state, freq, current, phase
// - Distinct codes for accel, decel, constant
// - Five history entries kept
// - Writing one clears all history
// - Fault reset pushes record to entry 1
// - Simultaneous trips share one entry
module drive_monitor
  import mon_pkg::*;
#(
  parameter int IN_TERMS = 5
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  input  wire logic [3:0]        ADDR,
  input  wire logic [15:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [15:0]       RDATA,
  output logic                   IRQ,
  input  wire logic [15:0]       OUT_VOLTAGE,
  input  wire logic [15:0]       OUT_POWER,
  input  wire logic [15:0]       TORQUE,
  input  wire logic [15:0]       V1_INPUT,
  input  wire logic [15:0]       I2_INPUT,
  input  wire logic              I2_MODE_SWITCH,
  input  wire logic [IN_TERMS-1:0] IN_TERM_PINS,
  input  wire logic              RELAY_OUT,
  input  wire logic              OC_OUT,
  input  wire logic [7:0]        TRIP,
  input  wire logic [5:0]        RUN_STATE,
  input  wire logic              ACCEL,
  input  wire logic              DECEL,
  input  wire logic [15:0]       OUT_FREQ,
  input  wire logic [15:0]       OUT_CURRENT,
  input  wire logic              FAULT_RESET,
  output logic      [15:0]       DISPLAY_VALUE,
  output logic      [2:0]        DISPLAY_LABEL,
  output logic      [2:0]        DISPLAY_STEP,
  output logic      [4:0]        POWER_ON_ITEM,
  output logic                   TRIP_ACTIVE
);

  initial begin
    if (IN_TERMS != 3 && IN_TERMS != 5) $error("drive_monitor: IN_TERMS must be 3 or 5");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           mon_sel;
    logic [4:0]           pwr_sel;
    logic [4:0]           pwr_item;
    logic                 hist_clr;
    logic [IN_TERMS-1:0]  in_s1;
    logic [IN_TERMS-1:0]  in_s2;
    logic [1:0]           out_s1;
    logic [1:0]           out_s2;
    logic                 sw_s1;
    logic                 sw_s2;
    logic                 tripped;
    logic [15:0]          rec;
    logic [15:0]          rec_freq;
    logic [15:0]          rec_curr;
    seq_t                 seq;
    logic                 push;
    logic [IRQ_W-1:0]     irq_st;
    logic [IRQ_W-1:0]     irq_mask;
    logic [15:0]          rdata;
    logic                 irq;
    logic [15:0]          disp;
    logic [2:0]           label;
    logic                 started;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [HIST_DEPTH*DATA_W-1:0] hist;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
    clamp = (v > lim) ? lim : v;
  endfunction : clamp

  function automatic logic [1:0] phase_code(input logic acc, input logic dec);
    if (acc) begin
      phase_code = PHASE_ACCEL;
    end else if (dec) begin
      phase_code = decel_trip_code;
    end else begin
      phase_code = PHASE_CONST;
    end
  endfunction : phase_code

  // ----------------------------------------------------------------------
  // History storage
  // ----------------------------------------------------------------------
  fault_history #(
    .DEPTH (HIST_DEPTH),
    .W     (DATA_W)
  ) u_hist (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .push    (s_q.push),
    .rec     (s_q.rec),
    .clear   (s_q.hist_clr),
    .entries (hist)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0]      val;
    logic [2:0]       lbl;
    logic [IRQ_W-1:0] ev;
    logic [3:0]       hidx;
    s_d = s_q;
    val = OUT_VOLTAGE;
    lbl = LBL_VOLTAGE;
    ev = '0;
    hidx = ADDR - REG_FAULT_HISTORY_BASE;

    // Synchronisers
    s_d.in_s1 = IN_TERM_PINS;
    s_d.in_s2 = s_q.in_s1;
    s_d.out_s1 = {RELAY_OUT, OC_OUT};
    s_d.out_s2 = s_q.out_s1;
    s_d.sw_s1 = I2_MODE_SWITCH;
    s_d.sw_s2 = s_q.sw_s1;

    // User-select monitor
    case (s_q.mon_sel)
      QTY_VOLTAGE: begin
        val = OUT_VOLTAGE;
        lbl = LBL_VOLTAGE;
      end
      QTY_POWER: begin
        val = OUT_POWER;
        lbl = LBL_POWER;
      end
      QTY_TORQUE: begin
        val = TORQUE;
        lbl = torque_label;
      end
      QTY_V1: begin
        val = V1_INPUT;
        lbl = v1_input_label;
      end
      QTY_I2: begin
        // Switch high selects current mode
        val = s_q.sw_s2 ? clamp(I2_INPUT, I2_CUR_MAX) : clamp(I2_INPUT, I2_VOL_MAX);
        lbl = s_q.sw_s2 ? i2_input_label : LBL_I2_VOLT_MODE;
      end
      default: begin
        val = OUT_VOLTAGE;
        lbl = LBL_VOLTAGE;
      end
    endcase
    s_d.disp = val;
    s_d.label = lbl;

    // Power-on item captured once after reset release
    if (!s_q.started) begin
      s_d.started = 1'b1;
      s_d.pwr_item = (s_q.pwr_sel >= PWR_ITEM_CURRENT && s_q.pwr_sel <= PWR_ITEM_USER_MON)
                     ? s_q.pwr_sel : PWR_SEL_RESET;
    end

    // Trip capture; all simultaneous trips land in one mask
    s_d.push = 1'b0;
    if (!s_q.tripped && (TRIP != 8'h00)) begin
      s_d.tripped = 1'b1;
      s_d.rec = {TRIP, phase_code(ACCEL, DECEL), RUN_STATE};
      s_d.rec_freq = OUT_FREQ;
      s_d.rec_curr = OUT_CURRENT;
      s_d.seq = SEQ_TYPE;
      ev[IRQ_TRIP] = 1'b1;
    end else if (s_q.tripped && FAULT_RESET) begin
      s_d.tripped = 1'b0;
      s_d.push = 1'b1;
      ev[IRQ_SHIFT] = 1'b1;
    end

    // Register reads
    s_d.rdata = 16'h0000;
    if (RD) begin
      case (ADDR)
        REG_USER_MONITOR_VALUE:    s_d.rdata = s_q.disp;
        REG_MONITOR_QUANTITY_SEL:  s_d.rdata = {13'h0000, s_q.mon_sel};
        REG_POWER_ON_DISPLAY_SEL:  s_d.rdata = {11'h000, s_q.pwr_sel};
        REG_INPUT_TERMINAL_STATE:  s_d.rdata = 16'(s_q.in_s2);
        REG_OUTPUT_TERMINAL_STATE: s_d.rdata = {14'h0000, s_q.out_s2};
        REG_ACTIVE_FAULT_RECORD: begin
          // Each read steps through the record
          case (s_q.seq)
            SEQ_TYPE:  s_d.rdata = {8'h00, s_q.rec[15:REC_TRIP_LSB]};
            SEQ_STATE: s_d.rdata = {10'h000, s_q.rec[REC_PHASE_LSB-1:0]};
            SEQ_FREQ:  s_d.rdata = s_q.rec_freq;
            SEQ_CURR:  s_d.rdata = s_q.rec_curr;
            SEQ_PHASE: s_d.rdata = {14'h0000, s_q.rec[REC_TRIP_LSB-1:REC_PHASE_LSB]};
            default:   s_d.rdata = 16'h0000;
          endcase
          case (s_q.seq)
            SEQ_TYPE:  s_d.seq = SEQ_STATE;
            SEQ_STATE: s_d.seq = SEQ_FREQ;
            SEQ_FREQ:  s_d.seq = SEQ_CURR;
            SEQ_CURR:  s_d.seq = SEQ_PHASE;
            default:   s_d.seq = SEQ_TYPE;
          endcase
        end
        REG_FAULT_HISTORY_CLEAR:   s_d.rdata = {15'h0000, s_q.hist_clr};
        REG_MONITOR_LABEL:         s_d.rdata = {13'h0000, s_q.label};
        REG_POWER_ON_ITEM:         s_d.rdata = {11'h000, s_q.pwr_item};
        REG_IRQ_STATUS:            s_d.rdata = 16'(s_q.irq_st);
        REG_IRQ_MASK:              s_d.rdata = 16'(s_q.irq_mask);
        default: begin
          if (hidx < 4'(HIST_DEPTH)) begin
            s_d.rdata = hist[hidx*DATA_W +: DATA_W];
          end
        end
      endcase
    end

    // Register writes
    s_d.hist_clr = HIST_CLEAR_RESET;
    if (WR) begin
      case (ADDR)
        REG_MONITOR_QUANTITY_SEL: begin
          // Out-of-range selections are ignored
          if (WDATA[2:0] <= MON_SEL_MAX) s_d.mon_sel = WDATA[2:0];
        end
        REG_POWER_ON_DISPLAY_SEL: s_d.pwr_sel = WDATA[4:0];
        REG_FAULT_HISTORY_CLEAR: begin
          if (WDATA[0]) begin
            s_d.hist_clr = 1'b1;
            ev[IRQ_CLEAR] = 1'b1;
          end
        end
        REG_IRQ_MASK:            s_d.irq_mask = WDATA[IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // Sticky status: set wins over write-one-to-clear
    if (WR && ADDR == REG_IRQ_STATUS) begin
      s_d.irq_st = s_q.irq_st & ~WDATA[IRQ_W-1:0];
    end
    s_d.irq_st = s_d.irq_st | ev;
    s_d.irq = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= '0;
      s_q.mon_sel <= MON_SEL_RESET;
      s_q.pwr_sel <= PWR_SEL_RESET;
      s_q.out_s2 <= OUT_STATE_RESET;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RDATA         = s_q.rdata;
  assign IRQ           = s_q.irq;
  assign DISPLAY_VALUE = s_q.disp;
  assign DISPLAY_LABEL = s_q.label;
  assign DISPLAY_STEP  = s_q.seq;
  assign POWER_ON_ITEM = s_q.pwr_item;
  assign TRIP_ACTIVE   = s_q.tripped;

endmodule : drive_monitor
`default_nettype wire

// file: src/mon_pkg.sv
/*
  Package for the drive monitor and fault history block: register indices,
  field layouts, reset values, codes and state encodings.
  Assumes a single system clock domain and a plain register port.
*/
package mon_pkg;

  // ----------------------------------------------------------------------
  // Register indices (word addresses on the plain port)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_USER_MONITOR_VALUE     = 4'h0;
  localparam logic [3:0] REG_MONITOR_QUANTITY_SEL   = 4'h1;
  localparam logic [3:0] REG_POWER_ON_DISPLAY_SEL   = 4'h2;
  localparam logic [3:0] REG_INPUT_TERMINAL_STATE   = 4'h3;
  localparam logic [3:0] REG_OUTPUT_TERMINAL_STATE  = 4'h4;
  localparam logic [3:0] REG_ACTIVE_FAULT_RECORD    = 4'h5;
  localparam logic [3:0] REG_FAULT_HISTORY_BASE     = 4'h6;
  localparam logic [3:0] REG_FAULT_HISTORY_CLEAR    = 4'hb;
  localparam logic [3:0] REG_MONITOR_LABEL          = 4'hc;
  localparam logic [3:0] REG_POWER_ON_ITEM          = 4'hd;
  localparam logic [3:0] REG_IRQ_STATUS             = 4'he;
  localparam logic [3:0] REG_IRQ_MASK               = 4'hf;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int         DATA_W            = 16;
  localparam int         HIST_DEPTH        = 5;
  localparam logic [2:0] MON_SEL_RESET     = 3'h0;
  localparam logic [2:0] MON_SEL_MAX       = 3'h4;
  localparam logic [4:0] PWR_SEL_RESET     = 5'h00;
  localparam logic [1:0] OUT_STATE_RESET   = 2'h0;
  localparam logic       HIST_CLEAR_RESET  = 1'b0;

  // ----------------------------------------------------------------------
  // Monitored quantity and label codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    QTY_VOLTAGE = 3'h0,
    QTY_POWER   = 3'h1,
    QTY_TORQUE  = 3'h2,
    QTY_V1      = 3'h3,
    QTY_I2      = 3'h4
  } quantity_t;

  typedef enum logic [2:0] {
    LBL_VOLTAGE      = 3'h0,
    LBL_POWER        = 3'h1,
    torque_label     = 3'h2,
    v1_input_label   = 3'h3,
    i2_input_label   = 3'h4,
    LBL_I2_VOLT_MODE = 3'h5
  } label_t;

  // Power-on display items
  localparam logic [4:0] PWR_ITEM_CURRENT   = 5'h0c;
  localparam logic [4:0] PWR_ITEM_SPEED     = 5'h0d;
  localparam logic [4:0] dc_link_monitor_item = 5'h0e;
  localparam logic [4:0] PWR_ITEM_USER_MON  = 5'h0f;

  // Accel/decel phase codes inside a fault record
  localparam logic [1:0] PHASE_CONST       = 2'h0;
  localparam logic [1:0] PHASE_ACCEL       = 2'h1;
  localparam logic [1:0] decel_trip_code   = 2'h2;

  // Fault record layout: [15:8] trip mask, [7:6] phase, [5:0] state code
  localparam int REC_TRIP_LSB  = 8;
  localparam int REC_PHASE_LSB = 6;

  // I2 scale limits in display units (0.01 mA / 0.01 V)
  localparam logic [15:0] I2_CUR_MAX = 16'h07d0;
  localparam logic [15:0] I2_VOL_MAX = 16'h03e8;

  // Interrupt status bits
  localparam int IRQ_TRIP  = 0;
  localparam int IRQ_SHIFT = 1;
  localparam int IRQ_CLEAR = 2;
  localparam int IRQ_W     = 3;

  // Record presentation sequence
  typedef enum logic [2:0] {
    SEQ_TYPE  = 3'b000,
    SEQ_STATE = 3'b001,
    SEQ_FREQ  = 3'b011,
    SEQ_CURR  = 3'b010,
    SEQ_PHASE = 3'b110
  } seq_t;

endpackage : mon_pkg

// file: src/fault_history.sv
/*
  Five-entry fault history shift register.
  Assumes push and clear are one-cycle pulses on SYS_CLK.
*/
`timescale 1ns/100ps
`default_nettype none
module fault_history #(
  parameter int DEPTH = 5,
  parameter int W     = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 push,
  input  wire logic [W-1:0]         rec,
  input  wire logic                 clear,
  output logic      [DEPTH*W-1:0]   entries
);

  initial begin
    if (DEPTH < 1 || W < 1) $error("fault_history: bad size");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] e;
  } hist_t;

  hist_t s_q;
  hist_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.e = '0;
    end else if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_d.e[i] = s_q.e[i-1];
      end
      s_d.e[0] = rec;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign entries = s_q.e;

endmodule : fault_history
`default_nettype wire

// file: test/keypad_model.sv
/*
  Keypad-side register master for drive_monitor: write and read tasks.
  Assumes the plain port: one-cycle strobes, read data one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module keypad_model (
  input  wire logic        clk,
  input  wire logic [15:0] rdata,
  output logic      [3:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd
);
  // --------------------------------
  // Bus cycles
  // --------------------------------
  initial begin
    addr  = 4'h0;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Released lines flip so stale values never pass
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : keypad_model
`default_nettype wire

// file: test/drive_monitor_assertions.sv
/*
  Port checker for drive_monitor: reads, terminals, trips, display codes.
  Assumes CE held high and one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_monitor_assertions
  import mon_pkg::*;
#(
  parameter int IN_TERMS = 5
) (
  input wire logic                SYS_CLK,
  input wire logic                RST_N,
  input wire logic [3:0]          ADDR,
  input wire logic                WR,
  input wire logic                RD,
  input wire logic [15:0]         RDATA,
  input wire logic                IRQ,
  input wire logic [IN_TERMS-1:0] IN_TERM_PINS,
  input wire logic                RELAY_OUT,
  input wire logic                OC_OUT,
  input wire logic [7:0]          TRIP,
  input wire logic                FAULT_RESET,
  input wire logic [15:0]         DISPLAY_VALUE,
  input wire logic [2:0]          DISPLAY_LABEL,
  input wire logic [2:0]          DISPLAY_STEP,
  input wire logic [4:0]          POWER_ON_ITEM,
  input wire logic                TRIP_ACTIVE
);
  // --------------------------------
  // Properties
  // --------------------------------
  // Age counter keeps $past clear of reset values
  logic [2:0] up_q;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  property p_rd_idle; !$past(RD) |-> RDATA == 16'h0000; endproperty
  property p_sel; RD && ADDR == REG_MONITOR_QUANTITY_SEL |=> RDATA <= 16'h0004; endproperty
  property p_in_term;
    $stable(IN_TERM_PINS)[*3] ##0 (up_q == 3'h7 && RD && ADDR == REG_INPUT_TERMINAL_STATE)
      |=> RDATA == 16'($past(IN_TERM_PINS));
  endproperty
  property p_out_term;
    $stable({RELAY_OUT, OC_OUT})[*3] ##0 (up_q == 3'h7 && RD && ADDR == REG_OUTPUT_TERMINAL_STATE)
      |=> RDATA == 16'($past({RELAY_OUT, OC_OUT}));
  endproperty
  property p_trip_take; !TRIP_ACTIVE && TRIP != 8'h00 |=> TRIP_ACTIVE; endproperty
  property p_trip_hold; TRIP_ACTIVE && !FAULT_RESET |=> TRIP_ACTIVE; endproperty
  property p_fault_rst; TRIP_ACTIVE && FAULT_RESET |=> !TRIP_ACTIVE; endproperty
  property p_pwr_item;
    POWER_ON_ITEM == 5'h00 || POWER_ON_ITEM inside {[PWR_ITEM_CURRENT:PWR_ITEM_USER_MON]};
  endproperty
  property p_step;
    DISPLAY_STEP inside {SEQ_TYPE, SEQ_STATE, SEQ_FREQ, SEQ_CURR, SEQ_PHASE};
  endproperty
  property p_i2_cur; DISPLAY_LABEL == i2_input_label |-> DISPLAY_VALUE <= I2_CUR_MAX; endproperty
  property p_i2_vol; DISPLAY_LABEL == LBL_I2_VOLT_MODE |-> DISPLAY_VALUE <= I2_VOL_MAX; endproperty
  property p_irq;
    RD && ADDR == REG_IRQ_STATUS && IRQ && !$past(WR) |=> RDATA != 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_sel: assert property (p_sel) else $error("monitor select above four");
  a_in_term: assert property (p_in_term) else $error("input state wrong");
  a_out_term: assert property (p_out_term) else $error("output state wrong");
  a_trip_take: assert property (p_trip_take) else $error("trip not taken");
  a_trip_hold: assert property (p_trip_hold) else $error("trip dropped");
  a_fault_rst: assert property (p_fault_rst) else $error("reset kept trip");
  a_pwr_item: assert property (p_pwr_item) else $error("bad power-on item");
  a_step: assert property (p_step) else $error("bad record step");
  a_i2_cur: assert property (p_i2_cur) else $error("current clamp broken");
  a_i2_vol: assert property (p_i2_vol) else $error("voltage clamp broken");
  a_irq: assert property (p_irq) else $error("irq with empty status");
  c_trip: cover property ($rose(TRIP_ACTIVE));
  c_reset: cover property ($fell(TRIP_ACTIVE));
  c_irq: cover property ($rose(IRQ));
endmodule : drive_monitor_assertions
bind drive_monitor drive_monitor_assertions #(.IN_TERMS(IN_TERMS)) drive_monitor_assertions_i (.*);
`default_nettype wire

// file: test/drive_monitor_tb_top.sv
/*
  Bench for drive_monitor: monitor select, terminals, trip record, history.
  Assumes keypad_model as register master and CE held high.
*/
`timescale 1ns/100ps
`default_nettype none
module drive_monitor_tb_top;
  import mon_pkg::*;
  // --------------------------------
  // Stimulus and checks
  // --------------------------------
  logic clk = 1'b0, rst_n = 1'b0, sw = 1'b1, relay = 1'b0, oc = 1'b0;
  logic accel = 1'b0, decel = 1'b0, frst = 1'b0, wr, rd, irq, tact;
  logic [4:0] pins = 5'h00;
  logic [7:0] trip = 8'h00;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [15:0] i2v = 16'h0900, frq = 16'h1234, cur = 16'h0567;
  logic [5:0] rs = 6'h2a;
  int n_fail = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  keypad_model keypad_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  drive_monitor drive_monitor_i (.SYS_CLK(clk), .RST_N(rst_n), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .OUT_VOLTAGE(16'h0111),
    .OUT_POWER(16'h0222), .TORQUE(16'h0333), .V1_INPUT(16'h0444), .I2_INPUT(i2v),
    .I2_MODE_SWITCH(sw), .IN_TERM_PINS(pins), .RELAY_OUT(relay), .OC_OUT(oc), .TRIP(trip),
    .RUN_STATE(rs), .ACCEL(accel), .DECEL(decel), .OUT_FREQ(frq),
    .OUT_CURRENT(cur), .FAULT_RESET(frst), .DISPLAY_VALUE(), .DISPLAY_LABEL(),
    .DISPLAY_STEP(), .POWER_ON_ITEM(), .TRIP_ACTIVE(tact));
  task automatic final_report;
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    keypad_model_i.rd_reg(a, d);
    chk(d, exp);
  endtask : rc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic trip_on(input logic [7:0] m, input logic a, input logic de);
    @(posedge clk);
    trip  <= m;
    accel <= a;
    decel <= de;
    @(posedge clk);
    trip <= 8'h00;
    for (int k = 0; k < 4 && tact !== 1'b1; k++) @(posedge clk);
    if (tact !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : trip_on
  task automatic trip_off;
    @(posedge clk);
    frst <= 1'b1;
    @(posedge clk);
    frst <= 1'b0;
    cyc(3);
  endtask : trip_off
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    cyc(2);
    rc(REG_MONITOR_QUANTITY_SEL, 16'h0000);
    rc(REG_POWER_ON_DISPLAY_SEL, 16'h0000);
    rc(REG_POWER_ON_ITEM, 16'h0000);
    rc(REG_OUTPUT_TERMINAL_STATE, 16'h0000);
    rc(REG_FAULT_HISTORY_CLEAR, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      keypad_model_i.wr_reg(REG_MONITOR_QUANTITY_SEL, 16'(i));
      cyc(3);
      rc(REG_USER_MONITOR_VALUE, (i < 4) ? 16'h0111 * 16'(i + 1) : I2_CUR_MAX);
      rc(REG_MONITOR_LABEL, 16'(i));
    end
    keypad_model_i.wr_reg(REG_MONITOR_QUANTITY_SEL, 16'h0005);
    rc(REG_MONITOR_QUANTITY_SEL, 16'h0004);
    @(posedge clk);
    sw    <= 1'b0;
    pins  <= 5'h15;
    relay <= 1'b1;
    cyc(4);
    rc(REG_USER_MONITOR_VALUE, I2_VOL_MAX);
    rc(REG_MONITOR_LABEL, 16'(LBL_I2_VOLT_MODE));
    rc(REG_INPUT_TERMINAL_STATE, 16'h0015);
    rc(REG_OUTPUT_TERMINAL_STATE, 16'h0002);
    // Below the clamp the input passes unchanged
    @(posedge clk);
    i2v <= 16'h0123;
    cyc(4);
    rc(REG_USER_MONITOR_VALUE, 16'h0123);
    // Two trip bits at once, decelerating
    trip_on(8'h05, 1'b0, 1'b1);
    rc(REG_ACTIVE_FAULT_RECORD, 16'h0005);
    rc(REG_ACTIVE_FAULT_RECORD, 16'h002a);
    rc(REG_ACTIVE_FAULT_RECORD, 16'h1234);
    rc(REG_ACTIVE_FAULT_RECORD, 16'h0567);
    chk(16'(irq), 16'h0000);
    keypad_model_i.wr_reg(REG_IRQ_MASK, 16'h0007);
    cyc(2);
    chk(16'(irq), 16'h0001);
    trip_off();
    rc(REG_FAULT_HISTORY_BASE, 16'h05aa);
    rc(REG_IRQ_STATUS, 16'h0003);
    keypad_model_i.wr_reg(REG_IRQ_STATUS, 16'h0003);
    cyc(2);
    chk(16'(irq), 16'h0000);
    // Six more trips overflow the history
    for (int j = 1; j <= 6; j++) begin
      trip_on(8'(j), j == 6, 1'b0);
      trip_off();
    end
    for (int k = 0; k < 5; k++)
      rc(REG_FAULT_HISTORY_BASE + 4'(k), {8'(6 - k), (k == 0) ? 2'h1 : 2'h0, 6'h2a});
    keypad_model_i.wr_reg(REG_FAULT_HISTORY_CLEAR, 16'h0001);
    cyc(2);
    for (int k = 0; k < 5; k++) rc(REG_FAULT_HISTORY_BASE + 4'(k), 16'h0000);
    rc(REG_FAULT_HISTORY_CLEAR, 16'h0000);
    final_report();
  end
  initial begin
    cyc(20000);
    n_fail++;
    final_report();
  end
endmodule : drive_monitor_tb_top
`default_nettype wire
